// file: hdl/sadc_top.sv
// converter control: bus slave, prescaler, trigger, sampling sequencer and result path
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_top import sadc_pkg::*; (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        comparator,
    input  wire logic [15:0] analog_trig_in,
    input  wire logic        timer_trigger_zero,
    input  wire logic        timer_trigger_one,
    output logic             adc_clk,
    output logic [3:0]       mux_channel,
    output logic             mux_enable,
    output logic [1:0]       ref_select,
    output logic             ref_enable,
    output logic             buffer_enable,
    output logic             direct_connect,
    output logic             buffer_bypass,
    output logic [9:0]       dac_code,
    output logic             dma_req
);
    // registers, plus next_state which is decoded combinationally
    logic [15:0] cmd_word;
    logic [31:0] result_word;
    logic        loss_flag;
    logic        done_flag;
    logic        unread;
    logic [7:0]  trig_ctl;
    logic [7:0]  prescale;
    logic [1:0]  samp_code;
    logic        dp_write;
    logic [4:0]  dp_addr;
    sadc_state_t state;
    sadc_state_t next_state;
    logic [7:0]  div_cnt;
    logic [4:0]  samp_cnt;
    logic        cmp_s1;
    logic        cmp_s2;
    logic [17:0] trig_s1;
    logic [17:0] trig_s2;
    logic        trig_prev;
    // wires
    logic        addr_phase;
    logic        rd_result;
    logic        wr_cmd;
    logic        wr_flag;
    logic [7:0]  div_lim;
    logic        conv_tick;
    logic [4:0]  samp_half;
    logic        samp_last;
    logic        trig_sel;
    logic        trig_pol;
    logic        trig_fire;
    logic        sar_start;
    logic        sar_done;
    logic [9:0]  sar_result;
    logic        store;
    logic [31:0] next_hrdata;
    logic        res8;
    logic        internal_conv;
    logic        sampling;

    // clamp the programmed divider into the legal window
    function automatic logic [7:0] sadc_clamp(input logic [7:0] p);
        if (p < `SADC_PRE_MIN)
            return `SADC_PRE_MIN;
        else if (p > `SADC_PRE_MAX)
            return `SADC_PRE_MAX;
        return p;
    endfunction : sadc_clamp

    // place the raw code in the selected format
    function automatic logic [15:0] sadc_format(input logic [9:0] r, input logic r8, input logic [1:0] fmt);
        logic [9:0] s;
        s = {~r[9], r[8:0]};
        case (fmt)
            FMT_RJ_UNS: return r8 ? {8'h00, r[9:2]} : {6'h00, r};
            FMT_RJ_SGN: return r8 ? {{8{s[9]}}, s[9:2]} : {{6{s[9]}}, s};
            default:    return r8 ? {r[9:2], 8'h00} : {r, 6'h00};
        endcase
    endfunction : sadc_format

    // bus decode; the slave never stalls and always answers okay
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign addr_phase = hsel && hready && htrans[1];
    assign rd_result  = addr_phase && !hwrite && (haddr[4:0] == `SADC_OFS_RESULT);
    assign wr_cmd     = dp_write && (dp_addr == `SADC_OFS_CMD);
    assign wr_flag    = dp_write && (dp_addr == `SADC_OFS_FLAG);

    // read mux, unmapped offsets read zero
    // command and result readable on the bus
    always_comb begin
        case (haddr[4:0])
            `SADC_OFS_CMD:      next_hrdata = {cmd_word, 16'h0000};
            `SADC_OFS_RESULT:   next_hrdata = result_word;
            `SADC_OFS_FLAG:     next_hrdata = {28'h0000000, dma_req, (state != ST_IDLE), done_flag, loss_flag};
            `SADC_OFS_TRIGCTL:  next_hrdata = {24'h000000, trig_ctl};
            `SADC_OFS_PRESCALE: next_hrdata = {24'h000000, prescale};
            `SADC_OFS_SAMPLE:   next_hrdata = {30'h00000000, samp_code};
            default:            next_hrdata = 32'h00000000;
        endcase
    end

    // address phase capture; read data registered for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr  <= 5'h00;
            hrdata   <= 32'h00000000;
        end else begin
            dp_write <= addr_phase && hwrite;
            dp_addr  <= haddr[4:0];
            if (addr_phase && !hwrite)
                hrdata <= next_hrdata;
        end
    end

    // configuration registers written in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_word  <= 16'h0000;
            trig_ctl  <= `SADC_RST_TRIGCTL;
            prescale  <= `SADC_RST_PRESCALE;
            samp_code <= `SADC_RST_SAMPLE;
        end else if (dp_write) begin
            if (dp_addr == `SADC_OFS_CMD)
                cmd_word <= hwdata[31:16];
            if (dp_addr == `SADC_OFS_TRIGCTL)
                trig_ctl <= hwdata[7:0];
            if (dp_addr == `SADC_OFS_PRESCALE)
                prescale <= hwdata[7:0];
            if (dp_addr == `SADC_OFS_SAMPLE)
                samp_code <= hwdata[1:0];
        end
    end

    // converter clock divided from bus clock
    assign div_lim   = sadc_clamp(prescale);
    assign conv_tick = (div_cnt == div_lim) && !adc_clk;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= 8'h00;
            adc_clk <= 1'b0;
        end else if (div_cnt == div_lim) begin
            div_cnt <= 8'h00;
            adc_clk <= ~adc_clk;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // two flops ahead of any trigger logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_s1 <= 18'h00000;
            trig_s2 <= 18'h00000;
            cmp_s1  <= 1'b0;
            cmp_s2  <= 1'b0;
        end else begin
            trig_s1 <= {timer_trigger_one, timer_trigger_zero, analog_trig_in};
            trig_s2 <= trig_s1;
            cmp_s1  <= comparator;
            cmp_s2  <= cmp_s1;
        end
    end

    // polarity applied before edge or level test
    assign trig_pol = trig_ctl[`SADC_TC_POL_BIT];
    always_comb begin
        case (sadc_trig_src_t'(trig_ctl[`SADC_TC_SRC_LSB +: 2]))
            TRG_ANALOG: trig_sel = trig_s2[trig_ctl[`SADC_TC_CH_LSB +: 4]] ~^ trig_pol;
            TRG_TIMER0: trig_sel = trig_s2[16] ~^ trig_pol;
            TRG_TIMER1: trig_sel = trig_s2[17] ~^ trig_pol;
            default:    trig_sel = 1'b0;
        endcase
    end
    assign trig_fire = trig_ctl[`SADC_TC_LEVEL_BIT] ? trig_sel : (trig_sel && !trig_prev);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            trig_prev <= 1'b0;
        else
            trig_prev <= trig_sel;
    end

    // internal references sample for two cycles only
    assign res8          = cmd_word[`SADC_CW_RES8_BIT - 16];
    assign internal_conv = cmd_word[`SADC_CW_INT_BIT - 16];
    assign samp_half     = (internal_conv ? `SADC_SAMP_INTERNAL : (`SADC_SAMP_BASE << samp_code)) >> 1;
    assign samp_last     = conv_tick && (samp_cnt == samp_half - 5'h01);
    assign sar_start     = (state == ST_SAMP_DIR) && samp_last;
    assign store         = (state == ST_STORE);
    assign sampling      = (state == ST_SAMP_BUF) || (state == ST_SAMP_DIR);

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:     next_state = state;
            ST_ARMED:    if (trig_fire) next_state = ST_SAMP_BUF;
            ST_SAMP_BUF: if (samp_last) next_state = ST_SAMP_DIR;
            ST_SAMP_DIR: if (samp_last) next_state = ST_CONVERT;
            ST_CONVERT:  if (sar_done) next_state = ST_STORE;
            ST_STORE:    next_state = cmd_word[`SADC_CW_TRIG_BIT - 16] ? ST_ARMED : ST_IDLE;
            default:     next_state = ST_IDLE;
        endcase
        // a command write aborts whatever runs and starts afresh
        if (wr_cmd)
            next_state = hwdata[`SADC_CW_TRIG_BIT] ? ST_ARMED : ST_SAMP_BUF;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state    <= ST_IDLE;
            samp_cnt <= 5'h00;
        end else begin
            state <= next_state;
            // count held at zero outside sampling, so a trigger never
            // inherits ticks from the armed wait and cuts the sample short
            if (wr_cmd || samp_last || !sampling)
                samp_cnt <= 5'h00;
            else if (conv_tick)
                samp_cnt <= samp_cnt + 5'h01;
        end
    end

    // bypass skips the buffer phase drive
    assign mux_channel    = cmd_word[`SADC_CW_CH_LSB - 16 +: 4];
    assign mux_enable     = (state == ST_SAMP_BUF || state == ST_SAMP_DIR) && !internal_conv;
    assign ref_select     = cmd_word[`SADC_CW_REF_LSB - 16 +: 2];
    assign ref_enable     = (state == ST_SAMP_BUF || state == ST_SAMP_DIR) && internal_conv;
    assign buffer_bypass  = cmd_word[`SADC_CW_BYP_BIT - 16];
    assign buffer_enable  = (state == ST_SAMP_BUF) && !buffer_bypass;
    assign direct_connect = (state == ST_SAMP_DIR) || ((state == ST_SAMP_BUF) && buffer_bypass);

    // approximation engine steps once per converter clock
    sadc_sar u_sar (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .start    (sar_start),
        .res8     (res8),
        .step     (conv_tick && (state == ST_CONVERT)),
        .cmp      (cmp_s2),
        .dac_code (dac_code),
        .result   (sar_result),
        .done     (sar_done)
    );

    // result store; the hardware set wins over a same-cycle clear
    // format chosen by the command field
    // command bits copied to result top
    // loss flag on overwriting an unread result
    // dma request raised per result, read drops it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_word <= 32'h00000000;
            loss_flag   <= 1'b0;
            done_flag   <= 1'b0;
            unread      <= 1'b0;
            dma_req     <= 1'b0;
        end else begin
            if (store)
                result_word <= {cmd_word,
                    sadc_format(sar_result, res8, cmd_word[`SADC_CW_FMT_LSB - 16 +: 2])};
            if (store && unread)
                loss_flag <= 1'b1;
            else if (wr_flag && hwdata[`SADC_FLG_LOSS_BIT])
                loss_flag <= 1'b0;
            if (store)
                done_flag <= 1'b1;
            else if (wr_flag && hwdata[`SADC_FLG_DONE_BIT])
                done_flag <= 1'b0;
            if (store) begin
                unread  <= 1'b1;
                dma_req <= 1'b1;
            end else if (rd_result) begin
                unread  <= 1'b0;
                dma_req <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence buf_phase_s;
        (state == ST_SAMP_BUF) && samp_last;
    endsequence
    sequence dir_phase_s;
        (state == ST_SAMP_DIR);
    endsequence

    conv_clk_range_a : assert property ($changed(adc_clk) |->
        ($past(div_cnt) >= `SADC_PRE_MIN && $past(div_cnt) <= `SADC_PRE_MAX))
        else $error("converter clock half period out of range");
    two_phase_a : assert property (buf_phase_s ##0 !wr_cmd |=> dir_phase_s)
        else $error("direct phase did not follow buffer phase");
    one_channel_a : assert property (mux_enable |-> (!ref_enable && mux_channel == cmd_word[3:0]))
        else $error("channel routing mismatch");
    bypass_path_a : assert property ((state == ST_SAMP_BUF && buffer_bypass) |->
        (!buffer_enable && direct_connect))
        else $error("bypass did not connect input directly");
    loss_set_a : assert property ((store && unread) |=> loss_flag)
        else $error("loss flag not set on overwrite");
    dma_raise_a : assert property (store |=> (dma_req && state != ST_STORE))
        else $error("dma request missing after result");
    dma_drop_a : assert property ((rd_result && !store) |=> !dma_req)
        else $error("result read did not withdraw dma request");
    result_top_a : assert property (store |=> (result_word[31:16] == $past(cmd_word)))
        else $error("command bits not copied into result");
    internal_samp_a : assert property ((state == ST_SAMP_BUF && internal_conv) |-> (samp_half == 5'h01))
        else $error("internal conversion sample not two cycles");
    trig_edge_a : assert property ((trig_fire && !trig_ctl[`SADC_TC_LEVEL_BIT]) |-> !trig_prev)
        else $error("edge trigger fired without edge");
endmodule : sadc_top

// file: hdl/sadc_params.svh
// offsets, field positions, reset values and timing counts of the converter control
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

// register byte offsets on the bus (low five address bits)
`define SADC_OFS_CMD        5'h00
`define SADC_OFS_RESULT     5'h04
`define SADC_OFS_FLAG       5'h08
`define SADC_OFS_TRIGCTL    5'h0C
`define SADC_OFS_PRESCALE   5'h10
`define SADC_OFS_SAMPLE     5'h14

// command word fields, upper half of the word
`define SADC_CW_CH_LSB      16
`define SADC_CW_FMT_LSB     21
`define SADC_CW_RES8_BIT    23
`define SADC_CW_INT_BIT     24
`define SADC_CW_REF_LSB     25
`define SADC_CW_BYP_BIT     27
`define SADC_CW_TRIG_BIT    28

// flag register bits
`define SADC_FLG_LOSS_BIT   0
`define SADC_FLG_DONE_BIT   1
`define SADC_FLG_BUSY_BIT   2
`define SADC_FLG_DMA_BIT    3

// trigger control fields
`define SADC_TC_SRC_LSB     0
`define SADC_TC_LEVEL_BIT   2
`define SADC_TC_POL_BIT     3
`define SADC_TC_CH_LSB      4

// reset values
`define SADC_RST_TRIGCTL    8'h08
`define SADC_RST_SAMPLE     2'h1

// converter clock limits and the prescaler bounds derived from them
`define SADC_HCLK_KHZ       200000
`define SADC_CONV_MAX_KHZ   2000
`define SADC_CONV_MIN_KHZ   500
`define SADC_HALF_MIN       ((`SADC_HCLK_KHZ + 2 * `SADC_CONV_MAX_KHZ - 1) / (2 * `SADC_CONV_MAX_KHZ))
`define SADC_HALF_MAX       (`SADC_HCLK_KHZ / (2 * `SADC_CONV_MIN_KHZ))
`define SADC_PRE_MIN        8'(`SADC_HALF_MIN - 1)
`define SADC_PRE_MAX        8'(`SADC_HALF_MAX - 1)
`define SADC_RST_PRESCALE   `SADC_PRE_MIN

// sample periods in converter clock cycles
`define SADC_SAMP_INTERNAL  5'h02
`define SADC_SAMP_BASE      5'h02

// approximation start and stop probes
`define SADC_PROBE_MSB      10'h200
`define SADC_PROBE_LSB10    10'h001
`define SADC_PROBE_LSB8     10'h004

`endif

// file: hdl/sadc_pkg.sv
// types shared by the converter control
package sadc_pkg;
    typedef enum logic [5:0] {
        ST_IDLE     = 6'b000001,
        ST_ARMED    = 6'b000010,
        ST_SAMP_BUF = 6'b000100,
        ST_SAMP_DIR = 6'b001000,
        ST_CONVERT  = 6'b010000,
        ST_STORE    = 6'b100000
    } sadc_state_t;

    typedef enum logic [1:0] {
        FMT_RJ_UNS = 2'h0,
        FMT_RJ_SGN = 2'h1,
        FMT_LJ_A   = 2'h2,
        FMT_LJ_B   = 2'h3
    } sadc_fmt_t;

    typedef enum logic [1:0] {
        TRG_ANALOG = 2'h0,
        TRG_TIMER0 = 2'h1,
        TRG_TIMER1 = 2'h2,
        TRG_NONE   = 2'h3
    } sadc_trig_src_t;
endpackage : sadc_pkg

// file: hdl/sadc_sar.sv
// successive approximation register with its step sequencing
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_sar import sadc_pkg::*; (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       start,
    input  wire logic       res8,
    input  wire logic       step,
    input  wire logic       cmp,
    output logic [9:0]      dac_code,
    output logic [9:0]      result,
    output logic            done
);
    logic [9:0] probe;
    logic       running;
    logic       last;
    logic [9:0] kept;

    // a low comparator answer drops the bit under trial, a high one keeps it
    assign kept = cmp ? dac_code : (dac_code & ~probe);
    assign last = (probe == (res8 ? `SADC_PROBE_LSB8 : `SADC_PROBE_LSB10));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac_code <= 10'h000;
            probe    <= 10'h000;
            running  <= 1'b0;
            result   <= 10'h000;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                dac_code <= `SADC_PROBE_MSB;
                probe    <= `SADC_PROBE_MSB;
                running  <= 1'b1;
            end else if (running && step) begin
                probe <= probe >> 1;
                if (last) begin
                    result   <= kept;
                    dac_code <= kept;
                    running  <= 1'b0;
                    done     <= 1'b1;
                end else begin
                    dac_code <= kept | (probe >> 1);
                end
            end
        end
    end

    // check that a kept decision survives the step
    sar_keep_bit_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (running && step && !start && cmp && !last) |=> ((dac_code & $past(probe)) == $past(probe)))
        else $error("kept decision bit lost after step");
    // eight-bit search leaves the two low result bits clear
    sar_res8_a : assert property (@(posedge hclk) disable iff (!hresetn)
        (done && res8) |-> (result[1:0] == 2'h0))
        else $error("eight-bit result has low bits set");
endmodule : sadc_sar

// file: bench/sadc_afe_model.sv
// behavioural analog front end: channel levels, storage node and comparator
`timescale 1ns/1ps
module sadc_afe_model (
    input  wire logic             hclk,
    input  wire logic [15:0][9:0] chan_level,
    input  wire logic [3:0]       mux_channel,
    input  wire logic             mux_enable,
    input  wire logic             buffer_enable,
    input  wire logic             direct_connect,
    input  wire logic [9:0]       dac_code,
    output logic                  comparator
);
    logic [9:0] held = 10'h000;

    // two path charging
    // node follows the routed channel while either path is closed, then holds
    always @(posedge hclk) begin
        if (mux_enable && (buffer_enable || direct_connect)) begin
            held <= chan_level[mux_channel];
        end
    end

    // half-step offset so no probe ever ties with the held level
    assign comparator = ({held, 1'b1} > {dac_code, 1'b0});
endmodule : sadc_afe_model

// file: bench/tb_sadc_top.sv
// self-checking bench for the converter control
`timescale 1ns/1ps
module tb_sadc_top;
    logic             hclk = 1'b0;
    logic             hresetn = 1'b0;
    logic             hsel = 1'b0;
    logic             hwrite = 1'b0;
    logic [1:0]       htrans = 2'h0;
    logic [31:0]      haddr = 32'h0;
    logic [31:0]      hwdata = 32'h0;
    logic [31:0]      hrdata;
    logic             hreadyout, hresp, comparator, adc_clk, mux_enable;
    logic             buffer_enable, direct_connect, dma_req, ref_enable, buffer_bypass;
    logic [1:0]       ref_select;
    logic [3:0]       mux_channel;
    logic [9:0]       dac_code;
    logic [15:0]      analog_trig_in = 16'h0;
    logic             timer_trigger_zero = 1'b0;
    logic             timer_trigger_one = 1'b0;
    logic [15:0][9:0] chan_level;
    int               n_mismatch = 0;
    int               check_count = 0;
    int               samp_n = 0;

    always #2.5 hclk = ~hclk;

    sadc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .comparator(comparator), .analog_trig_in(analog_trig_in),
        .timer_trigger_zero(timer_trigger_zero), .timer_trigger_one(timer_trigger_one), .adc_clk(adc_clk),
        .mux_channel(mux_channel), .mux_enable(mux_enable), .ref_select(ref_select), .ref_enable(ref_enable),
        .buffer_enable(buffer_enable), .direct_connect(direct_connect), .buffer_bypass(buffer_bypass),
        .dac_code(dac_code), .dma_req(dma_req));

    sadc_afe_model afe (.hclk(hclk), .chan_level(chan_level), .mux_channel(mux_channel),
        .mux_enable(mux_enable), .buffer_enable(buffer_enable), .direct_connect(direct_connect),
        .dac_code(dac_code), .comparator(comparator));

    // verdict, reached from the main sequence and from every expired wait
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic to_fail;
        n_mismatch++;
        $display("Error at %0t: wait ran out", $time);
        print_verdict();
    endtask : to_fail

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 16);
        if (hreadyout !== 1'b1) to_fail();
    endtask : wait_rdy

    // one single word transfer; read data taken at the data phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : bus

    // expected low half of the result word for a given level and format
    function automatic logic [15:0] fmt_res(input logic [9:0] v, input logic r8, input logic [1:0] f);
        logic [15:0] c;
        int          n;
        n = r8 ? 8 : 10;
        c = r8 ? 16'(v[9:2]) : 16'(v);
        if (f == 2'h1) begin
            c[n-1] = ~c[n-1];
            if (c[n-1]) c = c | (16'hFFFF << n);
        end else if (f[1]) begin
            c = c << (16 - n);
        end
        return c;
    endfunction : fmt_res

    task automatic drive_trig(input logic [1:0] s, input logic [3:0] c, input logic v);
        @(posedge hclk);
        if (s == 2'h0) analog_trig_in[c] <= v;
        if (s == 2'h1) timer_trigger_zero <= v;
        if (s == 2'h2) timer_trigger_one <= v;
    endtask : drive_trig

    // wait for a result while watching the order of the sampling paths and timing the sample;
    // outputs are looked at on the falling edge, where they have settled
    task automatic wait_conv(input logic byp);
        int   i;
        logic sb, bad;
        sb = 1'b0;
        bad = 1'b0;
        samp_n = 0;
        for (i = 0; i < 8000 && dma_req !== 1'b1; i++) begin
            @(negedge hclk);
            if (buffer_enable === 1'b1) sb = 1'b1;
            if (direct_connect === 1'b1 && !sb && !byp) bad = 1'b1;
            if (mux_enable === 1'b1 || ref_enable === 1'b1) samp_n++;
        end
        if (dma_req !== 1'b1) to_fail();
        chk({30'h0, bad, sb}, {30'h0, 1'b0, ~byp});
    endtask : wait_conv

    task automatic conv(input logic [3:0] ch, input logic [1:0] f, input logic r8, input logic byp,
                        input logic tr, input logic [7:0] tc);
        logic [31:0] cmd, rd;
        cmd = {3'h0, tr, byp, 2'h0, 1'b0, r8, f, 1'b0, ch, 16'h0000};
        bus(1'b1, 32'h0, cmd, rd);
        bus(1'b0, 32'h0, 32'h0, rd);
        chk(rd, cmd);
        if (tr) begin
            repeat (40) @(posedge hclk);
            chk({31'h0, dma_req}, 32'h0);
            drive_trig(tc[1:0], tc[7:4], tc[3]);
        end
        wait_conv(byp);
        if (tr) drive_trig(tc[1:0], tc[7:4], ~tc[3]);
        chk({28'h0, mux_channel}, {28'h0, ch});
        chk({31'h0, buffer_bypass}, {31'h0, byp});
        // four ticks of a 100-cycle converter clock; the command read-back hides the first few cycles
        chk({31'h0, samp_n > 296 && samp_n <= 400}, 32'h1);
        bus(1'b0, 32'h4, 32'h0, rd);
        chk(rd, {cmd[31:16], fmt_res(chan_level[ch], r8, f)});
        chk({31'h0, dma_req}, 32'h0);
    endtask : conv

    task automatic half_period(output int n);
        logic v;
        v = adc_clk;
        for (n = 0; n < 1000 && adc_clk === v; n++) @(negedge hclk);
        if (adc_clk === v) to_fail();
    endtask : half_period

    // main sequence: reset, corner cases, random traffic, loss, triggers, prescaler
    initial begin
        logic [31:0] rd;
        logic [7:0]  tcs[4];
        logic [7:0]  pre[3];
        logic [31:0] rst_adr[6];
        logic [31:0] rst_val[6];
        int          i, n;
        tcs = '{8'h58, 8'h09, 8'h01, 8'h0E};
        pre = '{8'h00, 8'h64, 8'hFF};
        rst_adr = '{32'h0, 32'h8, 32'hC, 32'h10, 32'h14, 32'h18};
        rst_val = '{32'h0, 32'h0, 32'h8, 32'h31, 32'h1, 32'h0};
        void'($urandom(32'h24ED));
        for (i = 0; i < 16; i++) chan_level[i] = 10'($urandom);
        chan_level[0] = 10'h000;
        chan_level[15] = 10'h3FF;
        repeat (20) @(posedge hclk);
        chk({16'h0, hresp, dma_req, adc_clk, buffer_enable, direct_connect, mux_enable, dac_code}, 32'h0);
        hresetn <= 1'b1;
        for (i = 0; i < 6; i++) begin
            bus(1'b0, rst_adr[i], 32'h0, rd);
            chk(rd, rst_val[i]);
        end
        bus(1'b1, 32'h14, 32'h1, rd);
        bus(1'b1, 32'h0, 32'h0, rd);
        wait_conv(1'b0);
        bus(1'b0, 32'h4, 32'h0, rd);
        // internal reference conversion: two converter ticks of sample
        bus(1'b1, 32'h0, 32'h0300_0000, rd);
        wait_conv(1'b0);
        chk({31'h0, samp_n > 100 && samp_n <= 200}, 32'h1);
        chk({30'h0, ref_select}, 32'h1);
        bus(1'b0, 32'h4, 32'h0, rd);
        chk({16'h0, rd[31:16]}, 32'h0300);
        conv(4'h0, 2'h1, 1'b0, 1'b0, 1'b0, 8'h0);
        conv(4'hF, 2'h1, 1'b1, 1'b1, 1'b0, 8'h0);
        conv(4'hF, 2'h3, 1'b0, 1'b0, 1'b0, 8'h0);
        conv(4'h0, 2'h2, 1'b1, 1'b0, 1'b0, 8'h0);
        for (i = 0; i < 10; i++) conv(4'($urandom), 2'($urandom), 1'($urandom), 1'($urandom), 1'b0, 8'h0);
        bus(1'b1, 32'h0, 32'h0005_0000, rd);
        wait_conv(1'b0);
        bus(1'b1, 32'h8, 32'h2, rd);
        bus(1'b1, 32'h0, 32'h0005_0000, rd);
        rd = 32'h0;
        for (i = 0; i < 8000 && rd[1] !== 1'b1; i++) bus(1'b0, 32'h8, 32'h0, rd);
        if (rd[1] !== 1'b1) to_fail();
        chk(rd & 32'hB, 32'hB);
        bus(1'b1, 32'h8, 32'h3, rd);
        bus(1'b0, 32'h8, 32'h0, rd);
        chk(rd & 32'hB, 32'h8);
        bus(1'b0, 32'h4, 32'h0, rd);
        for (i = 0; i < 4; i++) begin
            drive_trig(tcs[i][1:0], tcs[i][7:4], ~tcs[i][3]);
            bus(1'b1, 32'hC, {24'h0, tcs[i]}, rd);
            conv(4'($urandom), 2'h0, 1'b0, 1'b0, 1'b1, tcs[i]);
        end
        for (i = 0; i < 3; i++) begin
            bus(1'b1, 32'h10, {24'h0, pre[i]}, rd);
            half_period(n);
            half_period(n);
            half_period(n);
            chk(n, (pre[i] < 8'd49) ? 50 : (pre[i] > 8'd199) ? 200 : pre[i] + 1);
        end
        print_verdict();
    end
endmodule : tb_sadc_top
